/* File: inc/eepi_pkg.sv */
// Constants and types shared by the serial memory target.
`default_nettype none
package eepi_pkg;
    localparam int CLK_NS = 20;
    localparam int CLK_KHZ = 50000;
    localparam int GLITCH_NS = 100;
    localparam int GLITCH_CYC = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
    localparam int WRITE_MS = 10;
    localparam int WRITE_CYC = WRITE_MS * CLK_KHZ;
    localparam int ADDR_W = 15;
    localparam int PAGE_W = 6;
    localparam int MEM_BYTES = 32768;
    localparam int PAGE_BYTES = 64;
    localparam logic [3:0] DEV_TYPE = 4'ha;
    localparam logic DEV_B3 = 1'b0;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] STOP_SLOT_CNT = 4'h1;
    localparam logic [6:0] PAGE_CNT_MAX = 7'h40;
    localparam logic LINE_IDLE = 1'b1;

    typedef enum logic [5:0]
    {
        ST_IDLE = 6'h01,
        ST_RECV = 6'h02,
        ST_ACK = 6'h04,
        ST_SEND = 6'h08,
        ST_RACK = 6'h10,
        ST_WRITE = 6'h20
    } eepi_state_t;

    typedef enum logic [3:0]
    {
        KIND_SEL = 4'h1,
        KIND_ADH = 4'h2,
        KIND_ADL = 4'h4,
        KIND_DATA = 4'h8
    } eepi_kind_t;
endpackage : eepi_pkg
`default_nettype wire

/* File: inc/eepi_bus_if.sv */
// Filtered bus levels and the bus events derived from them.
`default_nettype none
interface eepi_bus_if;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;

    modport det
    (
        input scl,
        input sda,
        output scl_rise,
        output scl_fall,
        output start,
        output stop
    );

    modport core
    (
        input scl,
        input sda,
        input scl_rise,
        input scl_fall,
        input start,
        input stop
    );
endinterface : eepi_bus_if
`default_nettype wire

/* File: rtl/eepi_glitch_filter.sv */
// Synchroniser and glitch filter for one bus line.
`default_nettype none
module eepi_glitch_filter
(
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_arst_n,
    // Line.
    input wire logic i_raw,
    output logic o_level
);
    logic sync1_reg;
    logic sync2_reg;
    logic level_reg;
    logic [3:0] cnt_reg;

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            sync1_reg <= eepi_pkg::LINE_IDLE;
            sync2_reg <= eepi_pkg::LINE_IDLE;
        end
        else
        begin
            sync1_reg <= i_raw;
            sync2_reg <= sync1_reg;
        end
    end

    // A new level must persist past the glitch window before it is taken.
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            cnt_reg <= 4'h0;
            level_reg <= eepi_pkg::LINE_IDLE;
        end
        else if (sync2_reg == level_reg)
        begin
            cnt_reg <= 4'h0;
        end
        else if (cnt_reg == 4'(eepi_pkg::GLITCH_CYC))
        begin
            cnt_reg <= 4'h0;
            level_reg <= sync2_reg; // RULE15
        end
        else
        begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end

    assign o_level = level_reg;
endmodule : eepi_glitch_filter
`default_nettype wire

/* File: rtl/eepi_cond_detect.sv */
// Clock edge, START and STOP detection on the filtered bus.
`default_nettype none
module eepi_cond_detect
(
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_arst_n,
    // Bus.
    eepi_bus_if.det bus
);
    logic scl_q_reg;
    logic sda_q_reg;

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            scl_q_reg <= eepi_pkg::LINE_IDLE;
            sda_q_reg <= eepi_pkg::LINE_IDLE;
            bus.scl_rise <= 1'b0;
            bus.scl_fall <= 1'b0;
            bus.start <= 1'b0;
            bus.stop <= 1'b0;
        end
        else
        begin
            scl_q_reg <= bus.scl;
            sda_q_reg <= bus.sda;
            bus.scl_rise <= bus.scl & ~scl_q_reg;
            bus.scl_fall <= ~bus.scl & scl_q_reg;
            bus.start <= bus.scl & scl_q_reg & sda_q_reg & ~bus.sda;
            bus.stop <= bus.scl & scl_q_reg & ~sda_q_reg & bus.sda;
        end
    end
endmodule : eepi_cond_detect
`default_nettype wire

/* File: rtl/eepi_target.sv */
// Two-wire serial memory target: reads, page write cycle and polling.
//
// Notes on behaviour
// RULE1 - During the write cycle the bus is released and the page is copied in.
// RULE2 - The self-timed write cycle lasts at most 10 ms.
// RULE3 - Master polls with START and select; a busy target gives no acknowledge.
// RULE4 - After the write cycle a select byte is acknowledged as a new command.
// RULE5 - Reads behave the same whatever the write inhibit level.
// RULE6 - Random read: write select, address, repeated START, read select.
// RULE7 - Read select is acknowledged, addressed byte sent; master ends with NoAck, STOP.
// RULE8 - Both select bytes of a random read share the upper seven bits.
// RULE9 - Read select: acknowledge, send byte at counter, then advance counter.
// RULE10 - Master ends a current address read with NoAck then STOP.
// RULE11 - An acknowledged output byte is followed by the next address byte.
// RULE12 - Master ends a sequential read with NoAck then STOP.
// RULE13 - Counter increments after each output byte and wraps to zero.
// RULE14 - Acknowledge sampled in slot nine; without it the target goes idle.
// RULE15 - Pulses up to 100 ns on either line are filtered out.
// RULE16 - Only type 1010b with matching chip select bits is answered.
// RULE17 - Two address bytes, high byte first; the top bit is ignored.
// RULE18 - The data input is ignored while the write cycle runs.
// RULE19 - STOP after an unacknowledged read byte returns the target to idle.
// RULE20 - The 15-bit counter wraps and keeps the next address between reads.
`default_nettype none
module eepi_target
#(
    parameter int WRITE_CYC = eepi_pkg::WRITE_CYC
)
(
    // Clock and reset.
    input wire logic I_CLK_SYS,
    input wire logic I_ARST_N,
    // Bus pins.
    input wire logic I_SCL,
    input wire logic I_SDA,
    output logic O_SDA,
    output logic O_SDA_OE_N,
    // Strap pins.
    input wire logic I_WRITE_INHIBIT_PIN,
    input wire logic I_CHIP_SELECT_BIT0_PIN,
    input wire logic I_CHIP_SELECT_BIT1_PIN,
    // Status.
    output logic O_WRITE_BUSY
);
    eepi_bus_if bus ();

    logic scl_filt;
    logic sda_filt;
    logic [2:0] pin_sync1_reg;
    logic [2:0] pin_sync2_reg;
    eepi_pkg::eepi_state_t st_reg;
    eepi_pkg::eepi_kind_t kind_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] rx_reg;
    logic [7:0] tx_reg;
    logic rd_reg;
    logic ack_seen_reg;
    logic wp_reg;
    logic sda_oe_n_reg;
    logic sda_out_reg;
    logic busy_reg;
    logic [6:0] addr_hi_reg;
    logic [eepi_pkg::ADDR_W-1:0] addr_reg;
    logic [eepi_pkg::ADDR_W-1:0] wbase_reg;
    logic [6:0] page_cnt_reg;
    logic [6:0] cp_reg;
    logic [19:0] timer_reg;
    logic [7:0] mem [eepi_pkg::MEM_BYTES];
    logic [7:0] page_buf [eepi_pkg::PAGE_BYTES];
    logic sel_match;
    logic byte_done;
    logic accept;
    logic load_tx;
    logic ev_start;
    logic ev_stop;
    logic write_go;
    logic wr_done;
    logic copy_en;
    logic [eepi_pkg::ADDR_W-1:0] copy_addr;

    function automatic logic [eepi_pkg::ADDR_W-1:0] next_addr
    (
        input logic [eepi_pkg::ADDR_W-1:0] a
    );
        next_addr = a + 15'h0001;
    endfunction : next_addr

    function automatic logic [eepi_pkg::ADDR_W-1:0] page_addr
    (
        input logic [eepi_pkg::ADDR_W-1:0] base,
        input logic [6:0] off
    );
        page_addr = {base[eepi_pkg::ADDR_W-1:eepi_pkg::PAGE_W],
                     base[eepi_pkg::PAGE_W-1:0] + off[eepi_pkg::PAGE_W-1:0]};
    endfunction : page_addr

    eepi_glitch_filter u_scl_filt
    (
        .i_clk(I_CLK_SYS),
        .i_arst_n(I_ARST_N),
        .i_raw(I_SCL),
        .o_level(scl_filt)
    );

    eepi_glitch_filter u_sda_filt
    (
        .i_clk(I_CLK_SYS),
        .i_arst_n(I_ARST_N),
        .i_raw(I_SDA),
        .o_level(sda_filt)
    );

    assign bus.scl = scl_filt;
    assign bus.sda = sda_filt;

    eepi_cond_detect u_detect
    (
        .i_clk(I_CLK_SYS),
        .i_arst_n(I_ARST_N),
        .bus(bus)
    );

    // Strap pins cross into the clock domain through two flip-flops.
    always_ff @(posedge I_CLK_SYS or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            pin_sync1_reg <= 3'h0;
            pin_sync2_reg <= 3'h0;
        end
        else
        begin
            pin_sync1_reg <= {I_WRITE_INHIBIT_PIN, I_CHIP_SELECT_BIT1_PIN,
                              I_CHIP_SELECT_BIT0_PIN};
            pin_sync2_reg <= pin_sync1_reg;
        end
    end

    // START and STOP events are masked while the write cycle runs.
    assign ev_start = bus.start && (st_reg != eepi_pkg::ST_WRITE); // RULE18
    assign ev_stop = bus.stop && (st_reg != eepi_pkg::ST_WRITE); // RULE1
    assign sel_match = (rx_reg[7:4] == eepi_pkg::DEV_TYPE) && (rx_reg[3] == eepi_pkg::DEV_B3)
                       && (rx_reg[2:1] == pin_sync2_reg[1:0]); // RULE16
    assign byte_done = (st_reg == eepi_pkg::ST_RECV) && bus.scl_fall
                       && (bit_cnt_reg == eepi_pkg::BITS_PER_BYTE);
    always_comb
    begin
        unique case (kind_reg)
            eepi_pkg::KIND_SEL: accept = sel_match; // RULE16
            eepi_pkg::KIND_DATA: accept = !wp_reg;
            default: accept = 1'b1;
        endcase
    end
    assign load_tx = bus.scl_fall && (((st_reg == eepi_pkg::ST_ACK) && rd_reg)
                     || ((st_reg == eepi_pkg::ST_RACK) && ack_seen_reg)); // RULE9 RULE11
    assign write_go = ev_stop && (st_reg == eepi_pkg::ST_RECV)
                      && (kind_reg == eepi_pkg::KIND_DATA)
                      && (bit_cnt_reg == eepi_pkg::STOP_SLOT_CNT)
                      && (page_cnt_reg != 7'h00) && !wp_reg;
    assign wr_done = (timer_reg == 20'(WRITE_CYC - 1)); // RULE2
    assign copy_en = (st_reg == eepi_pkg::ST_WRITE) && (cp_reg < page_cnt_reg);
    assign copy_addr = page_addr(wbase_reg, cp_reg);

    // Protocol sequencing.
    always_ff @(posedge I_CLK_SYS or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            st_reg <= eepi_pkg::ST_IDLE;
            kind_reg <= eepi_pkg::KIND_SEL;
            bit_cnt_reg <= 4'h0;
            rd_reg <= 1'b0;
            ack_seen_reg <= 1'b0;
        end
        else if (ev_start)
        begin
            st_reg <= eepi_pkg::ST_RECV; // RULE3 RULE6
            kind_reg <= eepi_pkg::KIND_SEL;
            bit_cnt_reg <= 4'h0;
            rd_reg <= 1'b0;
        end
        else if (write_go)
        begin
            st_reg <= eepi_pkg::ST_WRITE; // RULE1
        end
        else if (ev_stop)
        begin
            st_reg <= eepi_pkg::ST_IDLE; // RULE19
        end
        else
        begin
            unique case (st_reg)
                eepi_pkg::ST_IDLE:
                begin
                    bit_cnt_reg <= 4'h0;
                end
                eepi_pkg::ST_RECV:
                begin
                    if (bus.scl_rise)
                    begin
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                    else if (byte_done)
                    begin
                        // Select byte chooses direction; a reject deselects.
                        st_reg <= accept ? eepi_pkg::ST_ACK : eepi_pkg::ST_IDLE;
                        if (kind_reg == eepi_pkg::KIND_SEL)
                        begin
                            rd_reg <= rx_reg[0]; // RULE4 RULE5
                        end
                    end
                end
                eepi_pkg::ST_ACK:
                begin
                    if (bus.scl_fall)
                    begin
                        bit_cnt_reg <= 4'h0;
                        st_reg <= rd_reg ? eepi_pkg::ST_SEND : eepi_pkg::ST_RECV; // RULE7
                        unique case (kind_reg)
                            eepi_pkg::KIND_SEL: kind_reg <= eepi_pkg::KIND_ADH;
                            eepi_pkg::KIND_ADH: kind_reg <= eepi_pkg::KIND_ADL;
                            default: kind_reg <= eepi_pkg::KIND_DATA;
                        endcase
                    end
                end
                eepi_pkg::ST_SEND:
                begin
                    if (bus.scl_rise)
                    begin
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                    else if (bus.scl_fall && (bit_cnt_reg == eepi_pkg::BITS_PER_BYTE))
                    begin
                        st_reg <= eepi_pkg::ST_RACK;
                    end
                end
                eepi_pkg::ST_RACK:
                begin
                    if (bus.scl_rise)
                    begin
                        ack_seen_reg <= !bus.sda; // RULE14
                    end
                    else if (bus.scl_fall)
                    begin
                        bit_cnt_reg <= 4'h0;
                        st_reg <= ack_seen_reg ? eepi_pkg::ST_SEND
                                               : eepi_pkg::ST_IDLE; // RULE14 RULE11
                    end
                end
                eepi_pkg::ST_WRITE:
                begin
                    if (wr_done)
                    begin
                        st_reg <= eepi_pkg::ST_IDLE; // RULE4
                    end
                end
                default:
                begin
                    st_reg <= eepi_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Receive shifting and transmit byte handling.
    always_ff @(posedge I_CLK_SYS or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            rx_reg <= 8'h00;
            tx_reg <= 8'h00;
        end
        else if ((st_reg == eepi_pkg::ST_RECV) && bus.scl_rise)
        begin
            rx_reg <= {rx_reg[6:0], bus.sda};
        end
        else if (load_tx)
        begin
            tx_reg <= mem[addr_reg]; // RULE9
        end
        else if ((st_reg == eepi_pkg::ST_SEND) && bus.scl_fall)
        begin
            tx_reg <= {tx_reg[6:0], 1'b0};
        end
    end

    // The line is pulled low only for an acknowledge or a zero data bit.
    always_ff @(posedge I_CLK_SYS or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            sda_oe_n_reg <= 1'b1;
            sda_out_reg <= 1'b0;
        end
        else if (ev_start || ev_stop || (st_reg == eepi_pkg::ST_WRITE))
        begin
            sda_oe_n_reg <= 1'b1; // RULE1 RULE3
        end
        else if (byte_done)
        begin
            sda_oe_n_reg <= !accept; // RULE4 RULE16
        end
        else if (load_tx)
        begin
            sda_oe_n_reg <= mem[addr_reg][7];
        end
        else if ((st_reg == eepi_pkg::ST_SEND) && bus.scl_fall)
        begin
            sda_oe_n_reg <= (bit_cnt_reg == eepi_pkg::BITS_PER_BYTE) ? 1'b1 : tx_reg[6];
        end
        else if (bus.scl_fall && (st_reg != eepi_pkg::ST_SEND))
        begin
            sda_oe_n_reg <= 1'b1;
        end
    end

    // Address counter and write setup.
    always_ff @(posedge I_CLK_SYS or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            addr_hi_reg <= 7'h00;
            addr_reg <= 15'h0000;
            wbase_reg <= 15'h0000;
            wp_reg <= 1'b0;
        end
        else if (load_tx)
        begin
            addr_reg <= next_addr(addr_reg); // RULE13 RULE20
        end
        else if (byte_done && (kind_reg == eepi_pkg::KIND_ADH))
        begin
            addr_hi_reg <= rx_reg[6:0]; // RULE17
        end
        else if (byte_done && (kind_reg == eepi_pkg::KIND_ADL))
        begin
            addr_reg <= {addr_hi_reg, rx_reg}; // RULE17 RULE6
            wbase_reg <= {addr_hi_reg, rx_reg};
            wp_reg <= pin_sync2_reg[2];
        end
        else if (byte_done && (kind_reg == eepi_pkg::KIND_DATA) && !wp_reg)
        begin
            addr_reg <= page_addr(addr_reg, 7'h01);
        end
    end

    // Page latch filling, write cycle timing and copy into the array.
    always_ff @(posedge I_CLK_SYS or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            page_cnt_reg <= 7'h00;
            cp_reg <= 7'h00;
            timer_reg <= 20'h00000;
            busy_reg <= 1'b0;
        end
        else if (st_reg == eepi_pkg::ST_WRITE)
        begin
            busy_reg <= !wr_done;
            timer_reg <= wr_done ? 20'h00000 : timer_reg + 20'h00001; // RULE2
            cp_reg <= copy_en ? cp_reg + 7'h01 : cp_reg;
            page_cnt_reg <= wr_done ? 7'h00 : page_cnt_reg;
        end
        else if (byte_done && (kind_reg == eepi_pkg::KIND_ADL))
        begin
            page_cnt_reg <= 7'h00;
            cp_reg <= 7'h00;
        end
        else if (byte_done && (kind_reg == eepi_pkg::KIND_DATA) && !wp_reg)
        begin
            page_cnt_reg <= (page_cnt_reg == eepi_pkg::PAGE_CNT_MAX) ? page_cnt_reg
                            : page_cnt_reg + 7'h01;
            cp_reg <= cp_reg + 7'h01;
        end
        else if (write_go)
        begin
            cp_reg <= 7'h00;
        end
    end

    always_ff @(posedge I_CLK_SYS)
    begin
        if (byte_done && (kind_reg == eepi_pkg::KIND_DATA) && !wp_reg)
        begin
            page_buf[cp_reg[eepi_pkg::PAGE_W-1:0]] <= rx_reg;
        end
        if (copy_en)
        begin
            mem[copy_addr] <= page_buf[cp_reg[eepi_pkg::PAGE_W-1:0]]; // RULE1
        end
    end

    assign O_SDA = sda_out_reg;
    assign O_SDA_OE_N = sda_oe_n_reg;
    assign O_WRITE_BUSY = busy_reg;
endmodule : eepi_target
`default_nettype wire

/* File: inc/eepi_unused_placeholder_do_not_compile.sv */
// Intentionally empty.
`default_nettype none
`default_nettype wire

/* File: test/eepi_target_monitor.sv */
// Pin-level checks for the serial memory target.
`default_nettype none
module eepi_target_monitor
#(
    parameter int WRITE_CYC = 600
)
(
    // Clock and reset.
    input wire logic I_CLK_SYS,
    input wire logic I_ARST_N,
    // Bus pins.
    input wire logic I_SCL,
    input wire logic I_SDA,
    input wire logic O_SDA,
    input wire logic O_SDA_OE_N,
    // Strap pins and status.
    input wire logic I_WRITE_INHIBIT_PIN,
    input wire logic I_CHIP_SELECT_BIT0_PIN,
    input wire logic I_CHIP_SELECT_BIT1_PIN,
    input wire logic O_WRITE_BUSY
);
    timeunit 1ns;
    timeprecision 100ps;
    int busy_cnt_reg;
    int low_cnt_reg;
    default clocking mon_cb @(posedge I_CLK_SYS);
    endclocking
    default disable iff (!I_ARST_N);
    // Counts the cycles of the running write cycle.
    always_ff @(posedge I_CLK_SYS or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
            busy_cnt_reg <= 0;
        else
            busy_cnt_reg <= O_WRITE_BUSY ? busy_cnt_reg + 1 : 0;
    end
    // Counts how long the target has held the line low.
    always_ff @(posedge I_CLK_SYS or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
            low_cnt_reg <= 0;
        else
            low_cnt_reg <= O_SDA_OE_N ? 0 : low_cnt_reg + 1;
    end
    busy_quiet_a: assert property (O_WRITE_BUSY |-> O_SDA_OE_N)
        else $error("Line driven during the write cycle.");
    busy_len_a: assert property (busy_cnt_reg <= WRITE_CYC + 1)
        else $error("Write cycle runs too long.");
    busy_cause_a: assert property ($rose(O_WRITE_BUSY) |-> I_SCL && I_SDA)
        else $error("Write cycle began without a stop.");
    busy_hold_a: assert property ($rose(O_WRITE_BUSY) |=> O_WRITE_BUSY [*8])
        else $error("Write cycle ended at once.");
    wake_quiet_a: assert property ($fell(O_WRITE_BUSY) |-> O_SDA_OE_N [*8])
        else $error("Line driven without a select.");
    drive_edge_a: assert property ($changed(O_SDA_OE_N) |-> !I_SCL && !$past(I_SCL, 4))
        else $error("Output changed outside the clock low phase.");
    stop_idle_a: assert property (I_SCL && $rose(I_SDA) |-> ##12 O_SDA_OE_N [*8])
        else $error("Line driven after a stop.");
    ack_span_a: assert property (low_cnt_reg <= 370)
        else $error("Line held low past one byte and slot.");
endmodule : eepi_target_monitor

bind eepi_target eepi_target_monitor #(.WRITE_CYC(WRITE_CYC)) u_monitor
(
    .I_CLK_SYS(I_CLK_SYS),
    .I_ARST_N(I_ARST_N),
    .I_SCL(I_SCL),
    .I_SDA(I_SDA),
    .O_SDA(O_SDA),
    .O_SDA_OE_N(O_SDA_OE_N),
    .I_WRITE_INHIBIT_PIN(I_WRITE_INHIBIT_PIN),
    .I_CHIP_SELECT_BIT0_PIN(I_CHIP_SELECT_BIT0_PIN),
    .I_CHIP_SELECT_BIT1_PIN(I_CHIP_SELECT_BIT1_PIN),
    .O_WRITE_BUSY(O_WRITE_BUSY)
);
`default_nettype wire

/* File: test/eepi_master_model.sv */
// Two-wire bus master that drives the clock and moves nine-bit slots.
`default_nettype none
module eepi_master_model
(
    // Clock.
    input wire logic i_clk,
    // Bus.
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda,
    // Result.
    output logic o_rx_valid,
    output logic [8:0] o_rx
);
    timeunit 1ns;
    timeprecision 100ps;
    logic glitch_en;
    initial
    begin
        o_scl = 1'b1;
        o_sda = 1'b1;
        o_rx_valid = 1'b0;
        o_rx = 9'h000;
        glitch_en = 1'b0;
    end
    task automatic q();
        repeat (10) @(posedge i_clk);
    endtask : q
    task automatic start_cond();
        o_sda <= 1'b1;
        q();
        o_scl <= 1'b1;
        q();
        o_sda <= 1'b0;
        q();
        o_scl <= 1'b0;
        q();
    endtask : start_cond
    task automatic stop_cond();
        o_sda <= 1'b0;
        q();
        o_scl <= 1'b1;
        q();
        o_sda <= 1'b1;
        q();
    endtask : stop_cond
    task automatic xfer(input logic [8:0] tx, input logic chk, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--)
        begin
            o_sda <= tx[i];
            q();
            o_scl <= 1'b1;
            q();
            rx[i] = i_sda;
            if (glitch_en && !tx[i])
            begin
                o_sda <= 1'b1;
                repeat (3) @(posedge i_clk);
                o_sda <= 1'b0;
                glitch_en = 1'b0;
            end
            q();
            o_scl <= 1'b0;
            q();
        end
        o_rx <= rx;
        o_rx_valid <= chk;
        @(posedge i_clk);
        o_rx_valid <= 1'b0;
    endtask : xfer
endmodule : eepi_master_model
`default_nettype wire

/* File: test/testbench.sv */
// Self-checking bench for the serial memory target.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int WCYC = 600;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic inhibit = 1'b0;
    logic [1:0] cs;
    logic scl;
    logic m_sda;
    logic sda_oe_n;
    logic sda_out;
    logic busy;
    logic rx_valid;
    logic [8:0] rx;
    logic [8:0] got;
    logic [8:0] expq[$];
    logic [7:0] mem[int];
    logic [14:0] ptr;
    logic [31:0] seed = 32'h00009c12;
    int fails = 0;
    int n_checks = 0;
    wire logic sda_wire = m_sda & (sda_oe_n | sda_out);
    always #10 clk = ~clk;
    eepi_target #(.WRITE_CYC(WCYC)) u_dut
    (
        .I_CLK_SYS(clk), .I_ARST_N(arst_n), .I_SCL(scl), .I_SDA(sda_wire),
        .O_SDA(sda_out), .O_SDA_OE_N(sda_oe_n), .I_WRITE_INHIBIT_PIN(inhibit),
        .I_CHIP_SELECT_BIT0_PIN(cs[0]), .I_CHIP_SELECT_BIT1_PIN(cs[1]), .O_WRITE_BUSY(busy)
    );
    eepi_master_model u_master
    (
        .i_clk(clk), .i_sda(sda_wire), .o_scl(scl), .o_sda(m_sda),
        .o_rx_valid(rx_valid), .o_rx(rx)
    );
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd
    function automatic logic [7:0] sel(input logic rw);
        return {eepi_pkg::DEV_TYPE, eepi_pkg::DEV_B3, cs, rw};
    endfunction : sel
    task automatic check(input logic [8:0] g, input logic [8:0] e);
        n_checks++;
        if (g !== e)
        begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : check
    task automatic slot(input logic [8:0] tx, input logic [8:0] e);
        expq.push_back(e);
        u_master.xfer(tx, 1'b1, got);
    endtask : slot
    always @(posedge clk)
        if (rx_valid === 1'b1)
            check(rx, (expq.size() > 0) ? expq.pop_front() : 9'hxxx);
    task automatic write_bytes(input logic [15:0] a, input int n);
        logic [7:0] d;
        u_master.start_cond();
        slot({sel(1'b0), 1'b1}, {sel(1'b0), 1'b0});
        slot({a[15:8], 1'b1}, {a[15:8], 1'b0});
        slot({a[7:0], 1'b1}, {a[7:0], 1'b0});
        for (int i = 0; i < n; i++)
        begin
            d = rnd();
            if (!inhibit)
                mem[int'({a[14:6], 6'(a[5:0] + 6'(i))})] = d;
            slot({d, 1'b1}, {d, inhibit});
        end
        u_master.stop_cond();
    endtask : write_bytes
    task automatic poll();
        int n;
        n = 0;
        u_master.start_cond();
        slot({sel(1'b0), 1'b1}, {sel(1'b0), 1'b1});
        while (got[0] !== 1'b0 && n < 8)
        begin
            u_master.start_cond();
            u_master.xfer({sel(1'b0), 1'b1}, 1'b0, got);
            n++;
        end
        check({8'h00, got[0]}, 9'h000);
    endtask : poll
    task automatic read_seq(input logic sel_done, input logic [15:0] a, input logic set_addr,
        input int n);
        logic [14:0] p;
        p = set_addr ? a[14:0] : ptr;
        if (set_addr)
        begin
            if (!sel_done)
            begin
                u_master.start_cond();
                slot({sel(1'b0), 1'b1}, {sel(1'b0), 1'b0});
            end
            slot({a[15:8], 1'b1}, {a[15:8], 1'b0});
            slot({a[7:0], 1'b1}, {a[7:0], 1'b0});
        end
        u_master.start_cond();
        slot({sel(1'b1), 1'b1}, {sel(1'b1), 1'b0});
        for (int i = 0; i < n; i++)
        begin
            slot({8'hff, i == n - 1}, {mem[int'(p)], i == n - 1});
            p = p + 15'h0001;
        end
        ptr = p;
        slot(9'h1ff, 9'h1ff);
        u_master.stop_cond();
    endtask : read_seq
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : finish_test
    initial
    begin
        repeat (80000) @(posedge clk);
        fails++;
        finish_test();
    end
    initial
    begin
        cs = 2'(rnd());
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        repeat (8) @(posedge clk);
        write_bytes(16'h0000, 3);
        poll();
        read_seq(1'b1, 16'h0000, 1'b1, 1);
        $display("Test write and poll done");
        write_bytes(16'hfffe, 2);
        poll();
        inhibit <= 1'b1;
        u_master.glitch_en = 1'b1;
        read_seq(1'b1, 16'h7ffe, 1'b1, 4);
        read_seq(1'b0, 16'h0000, 1'b0, 1);
        $display("Test reads done");
        write_bytes(16'h0001, 1);
        for (int k = 0; k < 3; k++)
        begin
            u_master.start_cond();
            got = (k == 0) ? {4'hb, 1'b0, cs, 2'b11} : (k == 1) ? {4'ha, 1'b1, cs, 2'b11}
                : {4'ha, 1'b0, ~cs, 2'b11};
            slot(got, got);
            u_master.stop_cond();
        end
        read_seq(1'b0, 16'h0001, 1'b1, 1);
        $display("Test select codes done");
        repeat (5) @(posedge clk);
        finish_test();
    end
endmodule : testbench
`default_nettype wire
